// >>> samc_ctrl.sv
// access mode command interpreter for the serial port
`timescale 1ns/1ps
module samc_ctrl #(
    parameter int XFER_BITS = samc_pkg::DEF_XFER_BITS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // serial pins, asynchronous to clk_i
    input wire logic sclk_i,
    input wire logic din_i,
    // decoded command state
    output logic [samc_pkg::SEL_BITS-1:0] reg_select_o,
    output logic write_active_o,
    output logic read_active_o,
    output logic cont_read_o,
    output logic cmd_wait_o,
    // one pulse per completed transfer, its data and the live shift register
    output logic xfer_done_o,
    output logic [XFER_BITS-1:0] xfer_data_o,
    output logic [XFER_BITS-1:0] shift_o,
    output logic cmd_valid_o,
    output logic [1:0] access_mode_o
);
    // bit counters are six bits wide; a word shorter than a command
    // byte could not carry the stop frame
    if (XFER_BITS < samc_pkg::CMD_BITS || XFER_BITS > 32) begin : g_bad_width
        $error("XFER_BITS out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and serial clock edge detect
    logic [1:0] sclk_sync;
    logic [1:0] din_sync;
    logic sclk_prev;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_sync <= 2'h0;
            din_sync <= 2'h0;
            sclk_prev <= 1'h0;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk_i};
            din_sync <= {din_sync[0], din_i};
            sclk_prev <= sclk_sync[1];
        end
    end
    // rising edge samples data in every state, continuous read included
    wire bit_strobe = sclk_sync[1] & ~sclk_prev;
    wire bit_val = din_sync[1];

    ////////////////////////////////////////////////////////////////////
    // shifting and bit counting
    samc_pkg::samc_state_t state, next_state;
    logic [XFER_BITS-1:0] shreg;
    logic [5:0] bit_cnt;
    samc_pkg::samc_cmd_t cmd;

    // write gate: a one at the first position is not taken in
    wire gate_hold = (state == samc_pkg::ST_CMD) && (bit_cnt == 6'h0)
                     && bit_val;
    wire in_cmd = (state == samc_pkg::ST_CMD);
    wire [5:0] last_cnt = in_cmd ? 6'(samc_pkg::CMD_BITS - 1)
                                 : 6'(XFER_BITS - 1);
    wire [5:0] cont_last = 6'(samc_pkg::CMD_BITS - 1);
    wire in_cont = (state == samc_pkg::ST_CONT);
    // in continuous read the stop byte is watched in byte frames
    wire frame_end = bit_strobe && !gate_hold
                     && (bit_cnt == (in_cont ? cont_last : last_cnt));
    wire [XFER_BITS-1:0] next_shreg = {shreg[XFER_BITS-2:0], bit_val};
    wire [7:0] new_byte = next_shreg[7:0];
    wire [1:0] new_mode = new_byte[samc_pkg::POS_MODE_HI:
                                   samc_pkg::POS_MODE_LO];
    wire [samc_pkg::SEL_BITS-1:0] new_sel =
        new_byte[samc_pkg::POS_SEL_HI:0];
    wire stop_seen = (new_byte == samc_pkg::STOP_BYTE);
    wire stop_cmd = (new_mode == samc_pkg::MODE_STOP)
                    && (new_byte[samc_pkg::POS_RSV_LO:0]
                        == samc_pkg::LOW_NIBBLE_ZERO);
    // read data is driven by the device; frames count read clocks only
    logic [5:0] cont_bits;

    always_comb begin
        next_state = state;
        unique case (state)
            samc_pkg::ST_CMD: begin
                if (frame_end) begin
                    unique case (new_mode)
                        samc_pkg::MODE_WRITE:
                            next_state = samc_pkg::ST_WRITE;
                        samc_pkg::MODE_READ:
                            next_state = samc_pkg::ST_READ;
                        samc_pkg::MODE_CONT:
                            next_state = samc_pkg::ST_CONT;
                        samc_pkg::MODE_STOP:
                            next_state = samc_pkg::ST_CMD;
                    endcase
                end
            end
            samc_pkg::ST_WRITE, samc_pkg::ST_READ: begin
                if (frame_end) begin
                    next_state = samc_pkg::ST_CMD;
                end
            end
            samc_pkg::ST_CONT: begin
                // stays here for each read until the stop byte arrives;
                // ones runs only matter through the stop frame, no reset
                if (frame_end && stop_seen && stop_cmd) begin
                    next_state = samc_pkg::ST_CMD;
                end
            end
            default: next_state = samc_pkg::ST_CMD;
        endcase
    end

    wire cmd_load = in_cmd && frame_end
                    && (new_mode != samc_pkg::MODE_STOP);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= samc_pkg::ST_CMD;
            shreg <= '0;
            bit_cnt <= 6'h0;
            cmd <= '0;
        end else begin
            state <= next_state;
            if (bit_strobe && !gate_hold) begin
                shreg <= next_shreg;
                bit_cnt <= frame_end ? 6'h0 : bit_cnt + 6'h1;
            end
            if (cmd_load) begin
                cmd <= '{mode: new_mode, sel: new_sel};
            end
        end
    end

    // counts clocks of a continuous read word to mark its end
    wire cont_word_end = in_cont && bit_strobe
                         && (cont_bits == 6'(XFER_BITS - 1));
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cont_bits <= 6'h0;
        end else if (!in_cont) begin
            cont_bits <= 6'h0;
        end else if (bit_strobe) begin
            cont_bits <= cont_word_end ? 6'h0 : cont_bits + 6'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            xfer_done_o <= 1'h0;
            xfer_data_o <= '0;
            cmd_valid_o <= 1'h0;
        end else begin
            xfer_done_o <= (frame_end && !in_cmd && !in_cont)
                           || cont_word_end;
            cmd_valid_o <= cmd_load;
            if (frame_end && !in_cmd) begin
                xfer_data_o <= next_shreg;
            end
        end
    end

    assign reg_select_o = cmd.sel;
    assign access_mode_o = cmd.mode;
    assign write_active_o = (state == samc_pkg::ST_WRITE);
    assign read_active_o = (state == samc_pkg::ST_READ);
    assign cont_read_o = in_cont;
    assign cmd_wait_o = in_cmd;
    assign shift_o = shreg;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_write_returns: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == samc_pkg::ST_WRITE && frame_end |=> in_cmd)
        else $error("single write did not return to command wait");
    a_read_returns: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == samc_pkg::ST_READ && frame_end |=> in_cmd)
        else $error("single read did not return to command wait");
    a_mode_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_cmd && frame_end && new_mode == samc_pkg::MODE_WRITE
        |=> write_active_o && reg_select_o == $past(new_sel))
        else $error("mode 00 did not start a write");
    a_mode_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_cmd && frame_end && new_mode == samc_pkg::MODE_READ
        |=> read_active_o && reg_select_o == $past(new_sel))
        else $error("mode 01 did not start a read");
    a_cont_enter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_cmd && frame_end && new_mode == samc_pkg::MODE_CONT
        |=> cont_read_o)
        else $error("mode 10 did not enter continuous read");
    a_cont_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_cont && !(frame_end && stop_seen) |=> in_cont)
        else $error("continuous read left without stop byte");
    a_cont_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_cont && frame_end && stop_seen |=> cmd_wait_o)
        else $error("stop byte did not end continuous read");
    a_cont_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_cont && $past(in_cont) |-> $stable(reg_select_o))
        else $error("select changed during continuous read");
    a_gate_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gate_hold |=> bit_cnt == 6'h0 && in_cmd)
        else $error("write gate one was taken in");
    a_cont_sample: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_cont && bit_strobe |=> shreg[0] == $past(bit_val))
        else $error("data not sampled in continuous read");
endmodule

// >>> samc_pkg.sv
// package for the serial access mode control block
package samc_pkg;
    localparam int CMD_BITS = 8;
    localparam int SEL_BITS = 3;
    // command byte field positions, msb first on the wire
    localparam int POS_WGATE = 7;
    localparam int POS_RSV_HI = 6;
    localparam int POS_MODE_HI = 5;
    localparam int POS_MODE_LO = 4;
    localparam int POS_RSV_LO = 3;
    localparam int POS_SEL_HI = 2;
    localparam logic [1:0] MODE_WRITE = 2'h0;
    localparam logic [1:0] MODE_READ = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [1:0] MODE_STOP = 2'h3;
    localparam logic [7:0] STOP_BYTE = 8'h30;
    localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;
    localparam int DEF_XFER_BITS = 8;

    typedef struct packed {
        logic [1:0] mode;
        logic [SEL_BITS-1:0] sel;
    } samc_cmd_t;

    typedef enum logic [3:0] {
        ST_CMD = 4'h1,
        ST_WRITE = 4'h2,
        ST_READ = 4'h4,
        ST_CONT = 4'h8
    } samc_state_t;
endpackage

// >>> samc_host.sv
// host serial port model that drives the clock and data pins
`timescale 1ns/1ps
module samc_host (
    // clock
    input wire logic clk_i,
    // serial pins
    output logic sclk_o,
    output logic din_o
);
    initial begin
        // clock stands still between frames
        sclk_o = 1'b0;
        din_o = 1'b0;
    end
    // every change lands just after a clk edge, never on it
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // msb first; callers keep whole bytes so stop frames stay aligned
    task automatic send(input logic [8:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            din_o = v[i];
            wait_clk(5);
            sclk_o = 1'b1;
            wait_clk(5);
            sclk_o = 1'b0;
        end
        din_o = 1'b0;
    endtask
endmodule

// >>> testbench.sv
// self-checking bench for the access mode command interpreter
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sclk, din, wr_act, rd_act, cont, cwait, done, cvalid;
    logic [samc_pkg::SEL_BITS-1:0] sel;
    logic [7:0] xdata, shift;
    logic [1:0] amode;
    int n_errors = 0;
    int total_checks = 0;
    int n_done = 0;
    int n_valid = 0;
    int nd, nv;
    // rows: command byte, data byte; reserved bits kept zero
    logic [7:0] rows [6][2] = '{'{8'h00, 8'h5A}, '{8'h07, 8'hFF},
        '{8'h13, 8'h00}, '{8'h16, 8'hC3}, '{8'h11, 8'h81}, '{8'h04, 8'h3C}};

    always #25 clk_i = ~clk_i;

    samc_host host_u (.clk_i(clk_i), .sclk_o(sclk), .din_o(din));
    samc_ctrl #(.XFER_BITS(8)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk), .din_i(din), .reg_select_o(sel),
        .write_active_o(wr_act), .read_active_o(rd_act), .cont_read_o(cont),
        .cmd_wait_o(cwait), .xfer_done_o(done), .xfer_data_o(xdata),
        .shift_o(shift), .cmd_valid_o(cvalid), .access_mode_o(amode));

    // pulses last one cycle, so count them on every edge
    always @(posedge clk_i) begin
        if (done === 1'b1) n_done <= n_done + 1;
        if (cvalid === 1'b1) n_valid <= n_valid + 1;
    end

    task automatic check(input logic [31:0] seen, exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t %s seen %0h exp %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic frame(input logic [8:0] v, input int n);
        nd = n_done;
        nv = n_valid;
        host_u.send(v, n);
        host_u.wait_clk(2);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_errors++;
        stop_test();
    end

    initial begin
        host_u.wait_clk(4);
        check({cwait, cont, wr_act, rd_act}, 4'h8, "reset state");
        rst_n_i = 1'b1;
        host_u.wait_clk(4);
        foreach (rows[r]) begin
            frame({1'b0, rows[r][0]}, 8);
            check(sel, rows[r][0][2:0], "select");
            check(amode, rows[r][0][5:4], "mode field");
            check(wr_act, !rows[r][0][4], "single write");
            check(rd_act, rows[r][0][4], "single read");
            check(n_valid - nv, 1, "command pulse");
            frame({1'b0, rows[r][1]}, 8);
            check(xdata, rows[r][1], "transfer data");
            check(shift, rows[r][1], "shift register");
            check(cwait, 1'b1, "back to command wait");
            check(n_done - nd, 1, "done pulse");
            $display("row %0d done", r);
        end
        // a one in the gate bit is held, then a zero opens it
        frame(9'h101, 9);
        check({wr_act, sel}, 4'h9, "gated write");
        frame(9'h000, 8);
        check(cwait, 1'b1, "gated write ends");
        // stop byte while waiting loads nothing
        frame(9'h030, 8);
        check({cwait, cont}, 2'h2, "stop in wait");
        check(n_valid - nv, 0, "no command pulse");
        $display("gate test done");
        frame(9'h022, 8);
        check({cont, sel}, 4'hA, "enter continuous");
        nd = n_done;
        repeat (3) host_u.send(9'h000, 8);
        host_u.wait_clk(2);
        check(n_done - nd, 3, "continuous reads");
        check({cont, cwait}, 2'h2, "still continuous");
        frame(9'h031, 8);
        check(cont, 1'b1, "nonzero low nibble keeps");
        frame(9'h030, 8);
        check({cwait, cont}, 2'h2, "stop byte");
        $display("continuous test done");
        // reset after a write command, before its data, drops the pending write
        frame(9'h001, 8);
        rst_n_i = 1'b0;
        host_u.wait_clk(4);
        check({cwait, cont, wr_act, rd_act}, 4'h8, "mid-run reset");
        rst_n_i = 1'b1;
        host_u.wait_clk(4);
        frame(9'h015, 8);
        check({rd_act, sel}, 4'hD, "read after reset");
        $display("reset test done");
        stop_test();
    end
endmodule
